/* rtl/ocwc_pkg.sv */
// Package with constants and types for the overcurrent window control block
package ocwc_pkg;

  // ----------------------------------------------------------------
  // Channels and timing
  // ----------------------------------------------------------------
  localparam int NCH           = 5;
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_TICK_NS     = 125000;
  localparam int TICK_CYC      = (T_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = 12;
  localparam int T_WIN1_US     = 2000;
  localparam int T_WIN2_US     = 8000;
  localparam int T_WIN3_US     = 64000;
  localparam int WIN1_TICKS    = T_WIN1_US * 1000 / T_TICK_NS;
  localparam int WIN2_TICKS    = T_WIN2_US * 1000 / T_TICK_NS;
  localparam int WIN3_TICKS    = T_WIN3_US * 1000 / T_TICK_NS;
  localparam int CNT_W         = 10;
  localparam int BALLAST_DIV   = 8;
  localparam int DIV_W         = 3;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] ADDR_GLOBAL     = 8'h00;
  localparam logic [7:0] ADDR_ON_DEMAND  = 8'h04;
  localparam logic [7:0] ADDR_OC_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_QUICK_STAT = 8'h0c;
  localparam logic [7:0] ADDR_CHAN_STAT0 = 8'h10;
  localparam int GLB_BALLAST_LSB   = 0;
  localparam int GLB_THERMAL_BIT   = 2;
  localparam int GLB_TRANSIENT_BIT = 3;
  localparam int OC_STATIC_LSB     = 0;
  localparam int OC_SHORT_LSB      = 8;
  localparam int OC_BYPASS_LSB     = 16;
  localparam int CST_STATE_LSB     = 1;
  localparam logic [1:0] BALLAST_ALL   = 2'h0;
  localparam logic [1:0] BALLAST_CH3   = 2'h1;
  localparam logic [1:0] BALLAST_CH34  = 2'h2;
  localparam logic [1:0] RST_BALLAST   = 2'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    OCWC_OFF,
    OCWC_FIRST,
    OCWC_SECOND,
    OCWC_THIRD,
    OCWC_STATIC
  } ocwc_state_t;

endpackage

/* rtl/ocwc_chan_if.sv */
// Interface between the control top and one channel window engine
`timescale 1ns/1ns
interface ocwc_chan_if;
  import ocwc_pkg::*;
  logic        on;
  logic        pwm;
  logic        full_duty;
  logic        open_load;
  logic        oc_trip;
  logic        tick;
  logic        bypass;
  logic        short_win;
  logic        ballast_en;
  logic        on_demand;
  ocwc_state_t state;
  logic        oc_event;

  modport top  (output on, pwm, full_duty, open_load, oc_trip, tick, bypass, short_win, ballast_en, on_demand,
                input  state, oc_event);
  modport chan (input  on, pwm, full_duty, open_load, oc_trip, tick, bypass, short_win, ballast_en, on_demand,
                output state, oc_event);
endinterface

/* rtl/ocwc_sync.sv */
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ns
module ocwc_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_bad_width
    $error("ocwc_sync width must be at least 1");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* rtl/ocwc_chan.sv */
// Window sequencer for one output channel
`timescale 1ns/1ns
module ocwc_chan (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  ocwc_chan_if.chan  cif
);
  import ocwc_pkg::*;

  logic             on_q;
  logic             on_rise;
  logic             restart;
  logic             in_window;
  logic             slowed;
  logic             step;
  logic             last;
  logic             ballast_armed;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] win_len;
  logic [DIV_W-1:0] div;
  ocwc_state_t      state;
  ocwc_state_t      next_state;

  assign cif.state = state;
  assign on_rise   = cif.on & ~on_q;
  // In PWM the control toggles every period, so only a start from off restarts
  assign restart   = on_rise & (~cif.pwm | (state == OCWC_OFF));
  assign in_window = (state == OCWC_FIRST) | (state == OCWC_SECOND) | (state == OCWC_THIRD);
  assign slowed    = (state == OCWC_SECOND) & ballast_armed & cif.full_duty & cif.open_load;
  assign step      = cif.tick & cif.on & (~slowed | (div == DIV_W'(BALLAST_DIV - 1)));
  assign last      = step & (cnt >= win_len - CNT_W'(1));

  always_comb begin
    case (state)
      OCWC_FIRST:  win_len = CNT_W'(WIN1_TICKS);
      OCWC_SECOND: win_len = CNT_W'(WIN2_TICKS);
      OCWC_THIRD:  win_len = CNT_W'(WIN3_TICKS);
      default:     win_len = CNT_W'(WIN3_TICKS);
    endcase
    if (cif.short_win) win_len = win_len >> 1;
  end

  always_comb begin
    next_state = state;
    if (restart) begin
      next_state = cif.bypass ? OCWC_STATIC : OCWC_FIRST;
    end else if (cif.on && on_q && cif.oc_trip && state != OCWC_OFF) begin
      next_state = (state == OCWC_STATIC && cif.on_demand) ? OCWC_SECOND : OCWC_OFF;
    end else if (!cif.on && !cif.pwm) begin
      next_state = OCWC_OFF;
    end else if (cif.on && cif.bypass && in_window) begin
      next_state = OCWC_STATIC;
    end else if (last) begin
      case (state)
        OCWC_FIRST:  next_state = OCWC_SECOND;
        OCWC_SECOND: next_state = OCWC_THIRD;
        OCWC_THIRD:  next_state = OCWC_STATIC;
        default:     next_state = state;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state <= OCWC_OFF;
    else          state <= next_state;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)                               cnt <= '0;
    else if (restart || next_state != state)    cnt <= '0;
    else if (step)                              cnt <= cnt + CNT_W'(1);
  end

  // Divider runs on gated ticks so the slowed window still only counts while on
  always_ff @(posedge aclk) begin
    if (!aresetn)                               div <= '0;
    else if (restart || next_state != state)    div <= '0;
    else if (cif.tick && cif.on && slowed)      div <= div + DIV_W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)     ballast_armed <= 1'b0;
    else if (restart) ballast_armed <= cif.ballast_en;
    else if (next_state == OCWC_SECOND && state == OCWC_STATIC) ballast_armed <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_q         <= 1'b0;
      cif.oc_event <= 1'b0;
    end else begin
      on_q         <= cif.on;
      cif.oc_event <= ~restart & cif.on & on_q & cif.oc_trip & (state != OCWC_OFF);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_restart_full: assert property (@(posedge aclk) disable iff (!aresetn)
    restart && !cif.bypass |=> state == OCWC_FIRST && cnt == '0)
    else $error("restart did not begin the first window");
  a_turn_on_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    restart && cif.bypass |=> state == OCWC_STATIC)
    else $error("bypassed turn-on did not select static threshold");
  a_bypass_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    !restart && cif.on && on_q && !cif.oc_trip && cif.bypass && in_window |=> state == OCWC_STATIC)
    else $error("bypass did not end the running window");
  a_rearm_second: assert property (@(posedge aclk) disable iff (!aresetn)
    !restart && cif.on && on_q && cif.oc_trip && cif.on_demand && state == OCWC_STATIC
    |=> state == OCWC_SECOND && !ballast_armed)
    else $error("on-demand rearm failed");
  a_default_trip: assert property (@(posedge aclk) disable iff (!aresetn)
    !restart && cif.on && on_q && cif.oc_trip && !cif.on_demand && state == OCWC_STATIC |=> state == OCWC_OFF)
    else $error("static trip without rearm did not shut off");
  a_gate_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    cif.pwm && !cif.on && state != OCWC_OFF |=> $stable(cnt))
    else $error("window counter moved while output off");
  a_ballast_div: assert property (@(posedge aclk) disable iff (!aresetn)
    slowed && cif.on && on_q && !cif.oc_trip && !cif.bypass && cif.tick && div != DIV_W'(BALLAST_DIV - 1)
    |=> $stable(cnt) && div == $past(div) + DIV_W'(1))
    else $error("second window not slowed by eight");
  a_direct_clock: assert property (@(posedge aclk) disable iff (!aresetn)
    state == OCWC_SECOND && !cif.open_load && cif.on && on_q && !cif.oc_trip && !cif.bypass && step && !last
    |=> cnt == $past(cnt) + CNT_W'(1))
    else $error("second window not clocked directly");
endmodule

/* rtl/ocwc_top.sv */
// Overcurrent window control for five outputs with an AXI4-Lite register slave
// Operation
// - Open load at full duty slows second window
// - Load present: second window clocked directly
// - Ballast extension stretches second window to 64ms
// - Extension armed each window start, not rearm
// - Ballast select picks which channels may extend
// - Default: after windows, static threshold only
// - On-demand: static trip reruns second, third windows
// - Overcurrent event clears channel's on-demand bit
// - Fault shown in quick and channel status
// - Static level select: 0 high, 1 low
// - Short-window bit halves every window
// - Bypass bit turns on without windows
// - Bypass ends running window immediately
// - Bypass while on selects static threshold
// - Thermal bit cuts first level when hot
// - Transient bit halves first-window level below detect voltage
// - Off-on toggle restarts windows, in PWM only from off; rewrite continues
// - Window counters advance only while commanded on
`timescale 1ns/1ns
module ocwc_top (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [ocwc_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]                     awprot,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [31:0]                    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  output logic [1:0]                          bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  input  wire logic [ocwc_pkg::ADDR_W-1:0]    araddr,
  input  wire logic [2:0]                     arprot,
  input  wire logic                           arvalid,
  output logic                                arready,
  output logic [31:0]                         rdata,
  output logic [1:0]                          rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  input  wire logic [ocwc_pkg::NCH-1:0]       channel_on_signal,
  input  wire logic [ocwc_pkg::NCH-1:0]       pwm_mode,
  input  wire logic [ocwc_pkg::NCH-1:0]       full_duty,
  input  wire logic [ocwc_pkg::NCH-1:0]       open_load,
  input  wire logic [ocwc_pkg::NCH-1:0]       oc_trip,
  input  wire logic [ocwc_pkg::NCH-1:0]       vout_below_detect,
  input  wire logic                           die_hot,
  input  wire logic                           fail_mode,
  output logic [3*ocwc_pkg::NCH-1:0]          window_state,
  output logic [ocwc_pkg::NCH-1:0]            static_level_low,
  output logic                                first_level_cut,
  output logic [ocwc_pkg::NCH-1:0]            high_level_halved,
  output logic [ocwc_pkg::NCH-1:0]            fault_flag
);
  import ocwc_pkg::*;

  localparam int SW = 6 * NCH + 2;

  // ----------------------------------------------------------------
  // Pin synchronisation and window tick
  // ----------------------------------------------------------------
  logic [SW-1:0]     pins_s;
  logic [NCH-1:0]    on_s;
  logic [NCH-1:0]    pwm_s;
  logic [NCH-1:0]    duty_s;
  logic [NCH-1:0]    ol_s;
  logic [NCH-1:0]    trip_s;
  logic [NCH-1:0]    vlow_s;
  logic              hot_s;
  logic              fail_s;
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;

  ocwc_sync #(.W(SW)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({fail_mode, die_hot, vout_below_detect, oc_trip, open_load, full_duty, pwm_mode,
                channel_on_signal}),
    .q       (pins_s)
  );
  assign {fail_s, hot_s, vlow_s, trip_s, ol_s, duty_s, pwm_s, on_s} = pins_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TICK_W'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == TICK_W'(TICK_CYC - 1)) ? '0 : tick_cnt + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [1:0]        ballast_select;
  logic              thermal_reduction_bit;
  logic              transient_reduction_bit;
  logic [NCH-1:0]    on_demand_rearm_bit;
  logic [NCH-1:0]    static_level_select;
  logic [NCH-1:0]    short_window_bit;
  logic [NCH-1:0]    window_bypass_bit;
  logic [NCH-1:0]    fault;
  logic [NCH-1:0]    fault_clr;
  logic [NCH-1:0]    chan_oc_ev;
  ocwc_state_t       chan_state [NCH];

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              do_write;
  logic [31:0]       wmask;
  logic [1:0]        eff_ballast;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign do_write = aw_held & w_held & ~bvalid;
  assign wmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // Address and data are taken in either order, the response follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      awready <= ~aw_held & ~(awvalid & awready) & ~bvalid;
      wready  <= ~w_held & ~(wvalid & wready) & ~bvalid;
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (aw_addr_q <= ADDR_OC_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ballast_select          <= RST_BALLAST;
      thermal_reduction_bit   <= 1'b0;
      transient_reduction_bit <= 1'b0;
      static_level_select     <= '0;
      short_window_bit        <= '0;
      window_bypass_bit       <= '0;
    end else if (do_write && aw_addr_q == ADDR_GLOBAL) begin
      {transient_reduction_bit, thermal_reduction_bit, ballast_select} <=
        4'(merge(32'(
          {transient_reduction_bit, thermal_reduction_bit, ballast_select}), w_data_q, wmask));
    end else if (do_write && aw_addr_q == ADDR_OC_CTRL) begin
      static_level_select <= NCH'(merge(32'(static_level_select), w_data_q >> OC_STATIC_LSB, wmask >> OC_STATIC_LSB));
      short_window_bit    <= NCH'(merge(32'(short_window_bit), w_data_q >> OC_SHORT_LSB, wmask >> OC_SHORT_LSB));
      window_bypass_bit   <= NCH'(merge(32'(window_bypass_bit), w_data_q >> OC_BYPASS_LSB, wmask >> OC_BYPASS_LSB));
    end
  end

  // A trip in the same cycle as a host write leaves the bit cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_demand_rearm_bit <= '0;
    end else if (do_write && aw_addr_q == ADDR_ON_DEMAND) begin
      on_demand_rearm_bit <= NCH'(merge(32'(on_demand_rearm_bit), w_data_q, wmask)) & ~chan_oc_ev;
    end else begin
      on_demand_rearm_bit <= on_demand_rearm_bit & ~chan_oc_ev;
    end
  end

  // Sticky fault; a new event wins over the read that clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) fault <= '0;
    else          fault <= (fault & ~fault_clr) | chan_oc_ev;
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [ADDR_W-1:0] rd_idx;

  assign rd_idx = (araddr - ADDR_CHAN_STAT0) >> 2;

  always_comb begin
    rd_mux    = '0;
    rd_ok     = 1'b1;
    fault_clr = '0;
    case (araddr)
      ADDR_GLOBAL:     rd_mux = 32'({transient_reduction_bit, thermal_reduction_bit, ballast_select});
      ADDR_ON_DEMAND:  rd_mux = 32'(on_demand_rearm_bit);
      ADDR_OC_CTRL:    rd_mux = (32'(window_bypass_bit) << OC_BYPASS_LSB) | (32'(short_window_bit) << OC_SHORT_LSB)
                                | (32'(static_level_select) << OC_STATIC_LSB);
      ADDR_QUICK_STAT: rd_mux = 32'(fault);
      default: begin
        if (araddr >= ADDR_CHAN_STAT0 && araddr[1:0] == 2'h0 && rd_idx < ADDR_W'(NCH)) begin
          rd_mux = (32'(chan_state[rd_idx[2:0]]) << CST_STATE_LSB) | 32'(fault[rd_idx[2:0]]);
          fault_clr[rd_idx[2:0]] = arvalid & arready;
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= ~rvalid & ~(arvalid & arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_mux;
        rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Fail mode forces every per-channel option except the on-demand rearm bit back to its reset meaning
  assign eff_ballast = fail_s ? BALLAST_ALL : ballast_select;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      ocwc_chan_if cif ();
      assign cif.on         = on_s[gi];
      assign cif.pwm        = pwm_s[gi];
      assign cif.full_duty  = duty_s[gi];
      assign cif.open_load  = ol_s[gi];
      assign cif.oc_trip    = trip_s[gi];
      assign cif.tick       = tick;
      assign cif.bypass     = window_bypass_bit[gi] & ~fail_s;
      assign cif.short_win  = short_window_bit[gi] & ~fail_s;
      assign cif.on_demand  = on_demand_rearm_bit[gi];
      assign cif.ballast_en = (eff_ballast == BALLAST_ALL) | ((eff_ballast == BALLAST_CH3) & (gi == 2))
                              | ((eff_ballast == BALLAST_CH34) & (gi == 2 || gi == 3));
      assign chan_oc_ev[gi] = cif.oc_event;
      assign chan_state[gi] = cif.state;

      ocwc_chan u_chan (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cif     (cif)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Threshold outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      window_state      <= '0;
      static_level_low  <= '0;
      first_level_cut   <= 1'b0;
      high_level_halved <= '0;
      fault_flag        <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        window_state[3*i +: 3] <= chan_state[i];
        high_level_halved[i]   <= transient_reduction_bit & vlow_s[i] & on_s[i]
                                  & (chan_state[i] == OCWC_FIRST);
      end
      static_level_low <= static_level_select & ~{NCH{fail_s}};
      first_level_cut  <= thermal_reduction_bit & hot_s;
      fault_flag       <= fault;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_od_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    |chan_oc_ev |=> (on_demand_rearm_bit & $past(chan_oc_ev)) == '0)
    else $error("on-demand bit not cleared by overcurrent");
  a_fault_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    |chan_oc_ev |=> ##1 (fault_flag & $past(chan_oc_ev, 2)) == $past(chan_oc_ev, 2))
    else $error("overcurrent not reported");
  a_fail_static: assert property (@(posedge aclk) disable iff (!aresetn)
    fail_s |=> static_level_low == '0)
    else $error("fail mode did not force high static level");
  a_thermal_cut: assert property (@(posedge aclk) disable iff (!aresetn)
    thermal_reduction_bit && hot_s |=> first_level_cut)
    else $error("thermal reduction not applied");
endmodule

/* tb/ocwc_host.sv */
// Host model: AXI4-Lite register master and channel on commands
`timescale 1ns/1ns
module ocwc_host
  import ocwc_pkg::*;
(
  input  wire logic        aclk,
  output logic [7:0]       addr = 8'h00,
  output logic             awvalid = 1'b0,
  input  wire logic        awready,
  output logic [31:0]      wdata = 32'h0,
  output logic [3:0]       wstrb = 4'hf,
  output logic             wvalid = 1'b0,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic [1:0]  bresp,
  output logic             bready = 1'b0,
  output logic             arvalid = 1'b0,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready = 1'b0,
  output logic [4:0]       chan_on = 5'h00
);
  logic [1:0] br = 2'h0;
  // Each channel keeps its item up until its own ready is seen at an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit aw = 1;
    bit w = 1;
    bit b = 1;
    int n = 0;
    @(posedge aclk);
    addr    <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (aw || w || b) begin
      @(posedge aclk);
      aw = aw && !awready;
      w  = w && !wready;
      if (b && bvalid) br = bresp;
      b  = b && !bvalid;
      awvalid <= aw;
      wvalid  <= w;
      bready  <= b;
      if (++n > 99) testbench.close_out(1);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    bit ar = 1;
    bit rr = 1;
    int n = 0;
    @(posedge aclk);
    addr    <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (ar || rr) begin
      @(posedge aclk);
      ar = ar && !arready;
      v  = rdata;
      r  = rresp;
      rr = rr && !rvalid;
      arvalid <= ar;
      rready  <= rr;
      if (++n > 99) testbench.close_out(1);
    end
  endtask
  task automatic sw(input int ch, input logic v);
    @(posedge aclk);
    chan_on[ch] <= v;
  endtask
  // Switching off first would leave the rearm armed for the next turn-on
  task automatic od_off(input logic [4:0] keep, input int ch);
    wr(ADDR_ON_DEMAND, {27'h0, keep});
    sw(ch, 1'b0);
  endtask
endmodule

/* tb/testbench.sv */
// Register-level testbench of the overcurrent window control block
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("unexpected %0t %h", $time, a); end end
module testbench;
  import ocwc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, die_hot = 1'b0, fail_mode = 1'b0;
  logic [4:0]  oc_trip = 5'h00, vout_below_detect = 5'h00;
  logic [4:0]  pwm_mode = 5'h00, full_duty = 5'h00, open_load = 5'h00;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic        first_level_cut;
  logic [1:0]  rresp, bresp, r;
  logic [3:0]  wstrb;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [4:0]  channel_on_signal, static_level_low, high_level_halved, fault_flag;
  logic [14:0] window_state;
  int          errors = 0, checked = 0, cyc = 0, t3, n;
  ocwc_top i_dut (
    .aclk, .aresetn, .awaddr(addr), .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr(addr), .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .channel_on_signal, .pwm_mode, .full_duty, .open_load, .oc_trip,
    .vout_below_detect, .die_hot, .fail_mode, .window_state, .static_level_low, .first_level_cut,
    .high_level_halved, .fault_flag);
  ocwc_host i_host (.aclk, .addr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid, .bresp, .bready,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .chan_on(channel_on_signal));
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  // Pins pass two sync flops before the engine reacts, so six edges settle
  task automatic tk(); repeat (6) @(posedge aclk); endtask
  function automatic logic [2:0] st(input int c); return window_state[3*c+:3]; endfunction
  task automatic close_out(input int hang = 0);
    errors += hang;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    i_host.rd(ADDR_GLOBAL, d, r); `CHK(d, 32'h0)
    i_host.rd(ADDR_OC_CTRL, d, r); `CHK(d, 32'h0)
    i_host.rd(8'h40, d, r); `CHK(r, RESP_SLVERR)
    i_host.wr(8'h40, 32'h0000_0015); `CHK(i_host.br, RESP_SLVERR)
    i_host.wr(ADDR_OC_CTRL, 32'h0000_0015); `CHK(i_host.br, RESP_OKAY)
    tk(); `CHK(static_level_low, 5'h15)
    fail_mode <= 1'b1;
    tk(); `CHK(static_level_low, 5'h00)
    fail_mode <= 1'b0;
    i_host.wr(ADDR_OC_CTRL, 32'h0011_0815);
    i_host.sw(3, 1'b1);
    t3 = cyc;
    i_host.sw(0, 1'b1);
    i_host.sw(1, 1'b1);
    i_host.sw(4, 1'b1);
    tk(); `CHK(st(0), OCWC_STATIC)
    `CHK(st(1), OCWC_FIRST)
    i_host.wr(ADDR_OC_CTRL, 32'h0013_0815);
    tk(); `CHK(st(1), OCWC_STATIC)
    oc_trip <= 5'h02;
    tk(); `CHK(st(1), OCWC_OFF)
    oc_trip <= 5'h00;
    `CHK(fault_flag[1], 1'b1)
    i_host.rd(ADDR_QUICK_STAT, d, r); `CHK(d[1], 1'b1)
    i_host.rd(ADDR_CHAN_STAT0 + 8'h04, d, r); `CHK(d[0], 1'b1)
    i_host.rd(ADDR_CHAN_STAT0 + 8'h04, d, r); `CHK(d[0], 1'b0)
    i_host.wr(ADDR_OC_CTRL, 32'h0003_0815);
    i_host.wr(ADDR_ON_DEMAND, 32'h0000_0010);
    oc_trip <= 5'h10;
    @(posedge aclk);
    oc_trip <= 5'h00;
    tk(); `CHK(st(4), OCWC_SECOND)
    i_host.rd(ADDR_ON_DEMAND, d, r); `CHK(d[4], 1'b0)
    i_host.od_off(5'h00, 4);
    tk(); `CHK(st(4), OCWC_OFF)
    i_host.wr(ADDR_GLOBAL, 32'h0000_0004);
    die_hot <= 1'b1;
    tk(); `CHK(first_level_cut, 1'b1)
    die_hot <= 1'b0;
    tk(); `CHK(first_level_cut, 1'b0)
    i_host.wr(ADDR_GLOBAL, 32'h0000_0008);
    vout_below_detect <= 5'h04;
    i_host.sw(2, 1'b1);
    tk(); `CHK(high_level_halved[2], 1'b1)
    for (n = 0; n < 30000 && st(3) === OCWC_FIRST; n++) @(posedge aclk);
    if (n == 30000) close_out(1);
    `CHK(st(3), OCWC_SECOND)
    `CHK((cyc - t3) > (WIN1_TICKS / 2 - 1) * TICK_CYC && (cyc - t3) < (WIN1_TICKS / 2 + 1) * TICK_CYC + 9, 1'b1)
    // Load present first, then open load, so both second-window clock paths run
    full_duty <= 5'h08;
    repeat (2 * TICK_CYC) @(posedge aclk);
    open_load <= 5'h08;
    repeat (3 * TICK_CYC) @(posedge aclk);
    `CHK(st(3), OCWC_SECOND)
    pwm_mode <= 5'h08;
    i_host.sw(3, 1'b0);
    tk(); `CHK(st(3), OCWC_SECOND)
    i_host.sw(3, 1'b1);
    tk(); `CHK(st(3), OCWC_SECOND)
    close_out();
  end
endmodule
